// [inc/dsb_params.svh]
// Purpose: Named constants for the drive stop and brake control block.
// Assumes: 250 MHz core clock, 32-bit register port with byte offsets.
// Notes:   Voltages are in volts, resistance in 0.1 ohm, power in 10 W.
`ifndef DSB_PARAMS_SVH
`define DSB_PARAMS_SVH

// ==========================================================
// Register map
`define DSB_OFS_CFG        8'h00
`define DSB_OFS_BRK        8'h04
`define DSB_OFS_PWR        8'h08
`define DSB_OFS_DIFN       8'h0C
`define DSB_OFS_CMD        8'h10
`define DSB_OFS_STAT       8'h14

// ==========================================================
// Reset values
`define DSB_RST_JOG_LOC    3'h1
`define DSB_RST_JOG_REM    3'h2
`define DSB_RST_STOP_MODE  3'h0
`define DSB_RST_CTRL_TYPE  4'h0
`define DSB_RST_CLASS      4'h2
`define DSB_RST_BRK_LVL    11'h2A3
`define DSB_RST_OHMS       13'h0000
`define DSB_RST_PWR        16'h0104
`define DSB_RST_DIFN       24'h000000

// ==========================================================
// Codes
`define DSB_JOG_OFF        3'h0
`define DSB_JOG_KEY        3'h1
`define DSB_JOG_DI         3'h2
`define DSB_JOG_SERIAL     3'h3
`define DSB_JOG_BUS0       3'h4
`define DSB_STOP_RAMP      3'h0
`define DSB_STOP_COAST     3'h1
`define DSB_STOP_FAST      3'h2
`define DSB_STOP_RAMP_IQ   3'h3
`define DSB_STOP_FAST_IQ   3'h4
`define DSB_CT_IQ_A        4'h4
`define DSB_CT_IQ_B        4'h6
`define DSB_FN_FWD         4'h4
`define DSB_FN_REV         4'h5
`define DSB_FN_RUN3        4'h6
`define DSB_FN_STOP3       4'h7
`define DSB_FN_JOG         4'hA
`define DSB_DI_N           6

// ==========================================================
// Supply classes and voltage limits
`define DSB_CLASS_MID      4'h5
`define DSB_CLASS_HI       4'h8
`define DSB_LVL_LO_MIN     11'h249
`define DSB_LVL_LO_MAX     11'h320
`define DSB_LVL_MID_MIN    11'h329
`define DSB_LVL_MID_MAX    11'h3E8
`define DSB_LVL_HI_MIN     11'h39C
`define DSB_LVL_HI_MAX     11'h4B0
`define DSB_BRK_HYST_V     11'h005

// ==========================================================
// Timing
`define DSB_CLK_NS         4
`define DSB_TICK_NS        1000000
`define DSB_TICK_CYCLES    (`DSB_TICK_NS / `DSB_CLK_NS)
`define DSB_ROL_TIME_S     120
`define DSB_ROL_TICKS      (`DSB_ROL_TIME_S * (1000000000 / `DSB_TICK_NS))
`define DSB_AVG_SHIFT      8

`endif

// [inc/dsb_pkg.sv]
// Purpose: Types shared by the drive stop and brake control files.
// Assumes: Field layouts fill one 32-bit register word each.
// Notes:   Pad and reserved fields are always kept at zero.
package dsb_pkg;

  // ==========================================================
  // Controller state and ramp request
  typedef enum logic [1:0] {
    DSB_ST_READY = 2'b00,
    DSB_ST_RUN   = 2'b01,
    DSB_ST_DECEL = 2'b10
  } dsb_state_t;

  typedef enum logic [1:0] {
    DSB_RAMP_HOLD  = 2'b00,
    DSB_RAMP_ACCEL = 2'b01,
    DSB_RAMP_DECEL = 2'b10,
    DSB_RAMP_ZERO  = 2'b11
  } dsb_ramp_t;

  // ==========================================================
  // Register layouts
  typedef struct packed {
    logic [11:0] rsvd;
    logic [3:0]  supply_voltage_class;
    logic [3:0]  control_type_select;
    logic        pad2;
    logic [2:0]  stop_mode_select;
    logic        pad1;
    logic [2:0]  jog_source_remote;
    logic        pad0;
    logic [2:0]  jog_source_local;
  } dsb_cfg_t;

  typedef struct packed {
    logic [2:0]  rsvd1;
    logic [12:0] brake_resistor_ohms;
    logic [4:0]  rsvd0;
    logic [10:0] brake_voltage_level;
  } dsb_brk_t;

  typedef struct packed {
    logic [29:0] rsvd;
    logic        fault_reset;
    logic        serial_jog;
  } dsb_cmd_t;

  typedef struct packed {
    logic [23:0] rsvd;
    logic        reverse;
    logic        jog_active;
    logic        brake_on;
    logic        resistor_overload_fault;
    logic        overvoltage_fault;
    logic        gate_enable;
    dsb_state_t  state;
  } dsb_stat_t;

endpackage

// [src/dsb_in_sync.sv]
// Purpose: Three-stage input synchroniser with agreement filter.
// Assumes: Inputs are asynchronous to the core clock.
// Notes:   A bit changes only once stages two and three agree.
`timescale 1ns/100ps
module dsb_in_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         core_clk_i,  // Core clock.
  input  wire logic         reset_n_i,   // Async reset, active low.
  input  wire logic [W-1:0] d_i,         // Raw pin levels.
  output logic      [W-1:0] q_o          // Filtered levels.
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // ==========================================================
  // Stage one feeds only stage two; the output follows agreeing stages.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q_o  <= '0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_o  <= (s2_q & s3_q) | (q_o & (s2_q ^ s3_q));
    end
  end

endmodule

// [src/dsb_ctrl.sv]
// Purpose: Stop, jog, run input and dynamic braking control of a drive.
// Assumes: Bus voltage and standstill flag arrive on the core clock.
// Notes:   Ramp shaping and the speed regulator sit outside this block.
`timescale 1ns/100ps
`include "dsb_params.svh"
module dsb_ctrl import dsb_pkg::*; #(
  parameter int unsigned TICK_CYCLES = `DSB_TICK_CYCLES,
  parameter int unsigned ROL_TICKS   = `DSB_ROL_TICKS
) (
  input  wire logic        core_clk_i,       // Core clock, 250 MHz.
  input  wire logic        reset_n_i,        // Async reset, active low.
  input  wire logic [7:0]  reg_addr_i,       // Register byte address.
  input  wire logic [31:0] reg_wdata_i,      // Register write data.
  input  wire logic        reg_wr_i,         // Write strobe.
  input  wire logic        reg_rd_i,         // Read strobe.
  output logic      [31:0] reg_rdata_o,      // Read data, one cycle later.
  input  wire logic [5:0]  din_i,            // Digital input pins.
  input  wire logic        remote_sel_i,     // High in remote situation.
  input  wire logic        keypad_jog_i,     // Keypad jog key level.
  input  wire logic [3:0]  fieldbus_jog_i,   // Jog levels, sources 4 to 7.
  input  wire logic        run_cmd_i,        // Run pulse, other sources.
  input  wire logic        stop_cmd_i,       // Stop pulse, other sources.
  input  wire logic        speed_zero_i,     // Motor at standstill.
  input  wire logic [10:0] dc_bus_volts_i,   // Measured bus voltage.
  output logic             gate_enable_o,    // Firing pulses allowed.
  output dsb_ramp_t        ramp_mode_o,      // Ramp request.
  output logic             reverse_o,        // Reverse direction.
  output logic             jog_o,            // Jog active.
  output logic             torque_ref_clear_o, // One-cycle clear pulse.
  output logic             brake_gate_o,     // Braking transistor on.
  output logic             overvoltage_fault_o,      // Bus overvoltage.
  output logic             resistor_overload_fault_o // Resistor overload.
);

  // ==========================================================
  // Declarations
  dsb_cfg_t    cfg_q;
  dsb_brk_t    brk_q;
  logic [15:0] brake_resistor_power_q;
  logic [23:0] difn_q;
  logic        serial_jog_q;
  logic        fault_reset;
  logic [5:0]  din_f;
  logic [5:0]  din_prev_q;
  logic [15:0] fn_lvl;
  logic [15:0] fn_rise;
  logic [15:0] fn_fall;
  logic [2:0]  jog_src;
  logic        jog_lvl;
  logic        jog_lvl_q;
  logic        start_ev;
  logic        stop_ev;
  logic        fault_any;
  logic        iq_modes_ok;
  dsb_state_t  state_q;
  logic [10:0] lvl_min;
  logic [10:0] lvl_max;
  logic [10:0] trip_lvl;
  logic [10:0] brk_lvl;
  logic [31:0] tick_cnt_q;
  logic        tick;
  logic [21:0] pwr_inst;
  logic [21:0] avg_q;
  logic [28:0] pwr_thr;
  logic [31:0] over_cnt_q;
  logic        wr_cmd;

  // ==========================================================
  // Pin synchroniser for all digital inputs.
  dsb_in_sync #(
    .W (`DSB_DI_N)
  ) u_din_sync (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .d_i        (din_i),
    .q_o        (din_f)
  );

  // ==========================================================
  // Register writes; reserved and pad bits are forced to zero.
  assign wr_cmd      = reg_wr_i && (reg_addr_i == `DSB_OFS_CMD);
  assign fault_reset = wr_cmd && reg_wdata_i[1];

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_q                          <= '0;
      cfg_q.jog_source_local         <= `DSB_RST_JOG_LOC;
      cfg_q.jog_source_remote        <= `DSB_RST_JOG_REM;
      cfg_q.stop_mode_select         <= `DSB_RST_STOP_MODE;
      cfg_q.control_type_select      <= `DSB_RST_CTRL_TYPE;
      cfg_q.supply_voltage_class     <= `DSB_RST_CLASS;
    end else if (reg_wr_i && (reg_addr_i == `DSB_OFS_CFG)) begin
      cfg_q      <= dsb_cfg_t'(reg_wdata_i);
      cfg_q.rsvd <= '0;
      cfg_q.pad0 <= 1'b0;
      cfg_q.pad1 <= 1'b0;
      cfg_q.pad2 <= 1'b0;
    end
  end

  // Brake level and resistor settings.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      brk_q                     <= '0;
      brk_q.brake_voltage_level <= `DSB_RST_BRK_LVL;
      brk_q.brake_resistor_ohms <= `DSB_RST_OHMS;
      brake_resistor_power_q    <= `DSB_RST_PWR;
    end else begin
      if (reg_wr_i && (reg_addr_i == `DSB_OFS_BRK)) begin
        brk_q       <= dsb_brk_t'(reg_wdata_i);
        brk_q.rsvd0 <= '0;
        brk_q.rsvd1 <= '0;
      end
      if (reg_wr_i && (reg_addr_i == `DSB_OFS_PWR)) begin
        brake_resistor_power_q <= reg_wdata_i[15:0];
      end
    end
  end

  // Input functions and the serial jog level.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      difn_q       <= `DSB_RST_DIFN;
      serial_jog_q <= 1'b0;
    end else begin
      if (reg_wr_i && (reg_addr_i == `DSB_OFS_DIFN)) begin
        difn_q <= reg_wdata_i[23:0];
      end
      if (wr_cmd) begin
        serial_jog_q <= reg_wdata_i[0];
      end
    end
  end

  // ==========================================================
  // Read port answers one cycle after the strobe; others read zero.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `DSB_OFS_CFG:  reg_rdata_o <= cfg_q;
        `DSB_OFS_BRK:  reg_rdata_o <= brk_q;
        `DSB_OFS_PWR:  reg_rdata_o <= {16'h0000, brake_resistor_power_q};
        `DSB_OFS_DIFN: reg_rdata_o <= {8'h00, difn_q};
        `DSB_OFS_CMD:  reg_rdata_o <= {31'h00000000, serial_jog_q};
        `DSB_OFS_STAT: reg_rdata_o <= dsb_stat_t'({24'h000000, reverse_o, jog_o,
                                        brake_gate_o, resistor_overload_fault_o,
                                        overvoltage_fault_o, gate_enable_o, state_q});
        default:       reg_rdata_o <= '0;
      endcase
    end else begin
      reg_rdata_o <= '0;
    end
  end

  // ==========================================================
  // Per-function input levels and edges; an input with an unused
  // function code is ignored.
  always_comb begin
    fn_lvl  = '0;
    fn_rise = '0;
    fn_fall = '0;
    for (int i = 0; i < `DSB_DI_N; i++) begin
      fn_lvl[difn_q[4*i +: 4]]  = fn_lvl[difn_q[4*i +: 4]] | din_f[i];
      fn_rise[difn_q[4*i +: 4]] = fn_rise[difn_q[4*i +: 4]] | (din_f[i] & ~din_prev_q[i]);
      fn_fall[difn_q[4*i +: 4]] = fn_fall[difn_q[4*i +: 4]] | (~din_f[i] & din_prev_q[i]);
    end
  end

  // Previous filtered levels for edge detection.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      din_prev_q <= '0;
      jog_lvl_q  <= 1'b0;
    end else begin
      din_prev_q <= din_f;
      jog_lvl_q  <= jog_lvl;
    end
  end

  // ==========================================================
  // Jog source selection by local or remote situation.
  assign jog_src = remote_sel_i ? cfg_q.jog_source_remote : cfg_q.jog_source_local;

  always_comb begin
    unique case (jog_src)
      `DSB_JOG_OFF:    jog_lvl = 1'b0;
      `DSB_JOG_KEY:    jog_lvl = keypad_jog_i;
      `DSB_JOG_DI:     jog_lvl = fn_lvl[`DSB_FN_JOG];
      `DSB_JOG_SERIAL: jog_lvl = serial_jog_q;
      default:         jog_lvl = fieldbus_jog_i[jog_src[1:0]];
    endcase
  end

  // ==========================================================
  // Start and stop events from all command paths.
  assign start_ev = run_cmd_i
                  | fn_rise[`DSB_FN_RUN3]
                  | fn_rise[`DSB_FN_FWD]
                  | (fn_rise[`DSB_FN_REV] & ~fn_lvl[`DSB_FN_FWD])
                  | (jog_lvl & ~jog_lvl_q);
  assign stop_ev  = stop_cmd_i
                  | fn_fall[`DSB_FN_STOP3]
                  | (fn_fall[`DSB_FN_FWD] & ~reverse_o)
                  | (fn_fall[`DSB_FN_REV] & reverse_o)
                  | (~jog_lvl & jog_lvl_q & jog_o);

  assign fault_any   = overvoltage_fault_o | resistor_overload_fault_o;
  assign iq_modes_ok = (cfg_q.control_type_select == `DSB_CT_IQ_A)
                     | (cfg_q.control_type_select == `DSB_CT_IQ_B);

  // ==========================================================
  // Run state machine; a fault or coast stop drops straight to Ready.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q            <= DSB_ST_READY;
      gate_enable_o      <= 1'b0;
      ramp_mode_o        <= DSB_RAMP_HOLD;
      torque_ref_clear_o <= 1'b0;
      jog_o              <= 1'b0;
    end else begin
      torque_ref_clear_o <= 1'b0;
      if (fault_any) begin
        state_q       <= DSB_ST_READY;
        gate_enable_o <= 1'b0;
        ramp_mode_o   <= DSB_RAMP_HOLD;
        jog_o         <= 1'b0;
      end else begin
        unique case (state_q)
          DSB_ST_READY: begin
            if (start_ev) begin
              state_q       <= DSB_ST_RUN;
              gate_enable_o <= 1'b1;
              ramp_mode_o   <= DSB_RAMP_ACCEL;
              jog_o         <= jog_lvl & ~jog_lvl_q;
            end
          end
          DSB_ST_RUN: begin
            if (stop_ev) begin
              jog_o <= 1'b0;
              unique case (cfg_q.stop_mode_select)
                `DSB_STOP_COAST: begin
                  state_q       <= DSB_ST_READY;
                  gate_enable_o <= 1'b0;
                  ramp_mode_o   <= DSB_RAMP_HOLD;
                end
                `DSB_STOP_FAST, `DSB_STOP_FAST_IQ: begin
                  state_q     <= DSB_ST_DECEL;
                  ramp_mode_o <= DSB_RAMP_ZERO;
                end
                default: begin
                  state_q     <= DSB_ST_DECEL;
                  ramp_mode_o <= DSB_RAMP_DECEL;
                end
              endcase
            end
          end
          DSB_ST_DECEL: begin
            if (start_ev) begin
              state_q     <= DSB_ST_RUN;
              ramp_mode_o <= DSB_RAMP_ACCEL;
            end else if (speed_zero_i) begin
              state_q            <= DSB_ST_READY;
              gate_enable_o      <= 1'b0;
              ramp_mode_o        <= DSB_RAMP_HOLD;
              torque_ref_clear_o <= iq_modes_ok
                  & ((cfg_q.stop_mode_select == `DSB_STOP_RAMP_IQ)
                   | (cfg_q.stop_mode_select == `DSB_STOP_FAST_IQ));
            end
          end
          default: begin
            state_q       <= DSB_ST_READY;
            gate_enable_o <= 1'b0;
            ramp_mode_o   <= DSB_RAMP_HOLD;
          end
        endcase
      end
    end
  end

  // Direction follows the forward and reverse run inputs.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reverse_o <= 1'b0;
    end else if (fn_rise[`DSB_FN_FWD]) begin
      reverse_o <= 1'b0;
    end else if (fn_rise[`DSB_FN_REV] && !fn_lvl[`DSB_FN_FWD]) begin
      reverse_o <= 1'b1;
    end
  end

  // ==========================================================
  // Class-dependent brake level window and overvoltage trip level.
  always_comb begin
    if (cfg_q.supply_voltage_class >= `DSB_CLASS_HI) begin
      lvl_min = `DSB_LVL_HI_MIN;
      lvl_max = `DSB_LVL_HI_MAX;
    end else if (cfg_q.supply_voltage_class >= `DSB_CLASS_MID) begin
      lvl_min = `DSB_LVL_MID_MIN;
      lvl_max = `DSB_LVL_MID_MAX;
    end else begin
      lvl_min = `DSB_LVL_LO_MIN;
      lvl_max = `DSB_LVL_LO_MAX;
    end
    trip_lvl = lvl_max;
    brk_lvl  = brk_q.brake_voltage_level;
    if (brk_lvl < lvl_min) begin
      brk_lvl = lvl_min;
    end else if (brk_lvl > lvl_max) begin
      brk_lvl = lvl_max;
    end
  end

  // Brake transistor with a small hysteresis band; off under any fault.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      brake_gate_o <= 1'b0;
    end else if (fault_any) begin
      brake_gate_o <= 1'b0;
    end else if (dc_bus_volts_i >= brk_lvl) begin
      brake_gate_o <= 1'b1;
    end else if (dc_bus_volts_i < (brk_lvl - `DSB_BRK_HYST_V)) begin
      brake_gate_o <= 1'b0;
    end
  end

  // ==========================================================
  // One millisecond tick for the resistor overload timing.
  assign tick = (tick_cnt_q == (TICK_CYCLES - 32'd1));

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_cnt_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'd1;
    end
  end

  // Power check: V*V*duty against P*R, in the 10 W and 0.1 ohm units.
  assign pwr_inst = brake_gate_o ? (22'(dc_bus_volts_i) * 22'(dc_bus_volts_i)) : '0;
  assign pwr_thr  = 29'(brake_resistor_power_q) * 29'(brk_q.brake_resistor_ohms);

  // Leaky average of resistor power, updated once per tick.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      avg_q <= '0;
    end else if (tick) begin
      if (pwr_inst >= avg_q) begin
        avg_q <= avg_q + ((pwr_inst - avg_q) >> `DSB_AVG_SHIFT);
      end else begin
        avg_q <= avg_q - ((avg_q - pwr_inst) >> `DSB_AVG_SHIFT);
      end
    end
  end

  // Overload time counter; zero resistance disables the protection.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      over_cnt_q <= '0;
    end else if (brk_q.brake_resistor_ohms == `DSB_RST_OHMS) begin
      over_cnt_q <= '0;
    end else if (29'(avg_q) <= pwr_thr) begin
      over_cnt_q <= '0;
    end else if (tick && (over_cnt_q < ROL_TICKS)) begin
      over_cnt_q <= over_cnt_q + 32'd1;
    end
  end

  // ==========================================================
  // Sticky faults; a new trip in the reset cycle wins over the reset.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      overvoltage_fault_o       <= 1'b0;
      resistor_overload_fault_o <= 1'b0;
    end else begin
      if (dc_bus_volts_i > trip_lvl) begin
        overvoltage_fault_o <= 1'b1;
      end else if (fault_reset) begin
        overvoltage_fault_o <= 1'b0;
      end
      if (over_cnt_q >= ROL_TICKS) begin
        resistor_overload_fault_o <= 1'b1;
      end else if (fault_reset) begin
        resistor_overload_fault_o <= 1'b0;
      end
    end
  end

endmodule

// [tb/dsb_ctrl_sva.sv]
// Purpose: Checker for stop and brake outputs.
// Assumes: Class 2 and a 675 V brake level.
// Notes: Bound to dsb_ctrl below.
`timescale 1ns/100ps
module dsb_ctrl_sva (
  input wire logic        core_clk_i,                // Clock.
  input wire logic        reset_n_i,                 // Reset.
  input wire logic        reg_rd_i,                  // Read.
  input wire logic [31:0] reg_rdata_o,               // Data.
  input wire logic [10:0] dc_bus_volts_i,            // Bus.
  input wire logic        gate_enable_o,             // Gate.
  input wire logic        brake_gate_o,              // Brake.
  input wire logic        overvoltage_fault_o,       // Trip.
  input wire logic        resistor_overload_fault_o, // Overload.
  input wire logic        torque_ref_clear_o         // Clear.
);
  // All checks share the core clock and reset.
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  chk_ov_trip: assert property (dc_bus_volts_i > 11'h320 |=> overvoltage_fault_o) else $error("trip");
  chk_ov_clear: assert property ($fell(overvoltage_fault_o) |-> $past(dc_bus_volts_i) <= 11'h320) else $error("ovc");
  // A registered fault removes gate and brake one cycle after it is raised.
  chk_fault_gate: assert property (overvoltage_fault_o || resistor_overload_fault_o
    |=> !gate_enable_o && !brake_gate_o) else $error("gate");
  chk_brake_on: assert property (dc_bus_volts_i >= 11'h2A3 && dc_bus_volts_i <= 11'h320 && !overvoltage_fault_o
    |=> brake_gate_o || resistor_overload_fault_o) else $error("bon");
  chk_brake_off: assert property (dc_bus_volts_i < 11'h29E |=> !brake_gate_o) else $error("boff");
  chk_brake_rise: assert property ($rose(brake_gate_o) |-> $past(dc_bus_volts_i) >= 11'h2A3) else $error("brs");
  chk_clear_pulse: assert property (torque_ref_clear_o |=> !torque_ref_clear_o) else $error("clr");
  chk_clear_stop: assert property (torque_ref_clear_o |-> !gate_enable_o && $past(gate_enable_o)) else $error("cst");
  chk_rd_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0) else $error("rd");
endmodule
bind dsb_ctrl dsb_ctrl_sva u_sva (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .dc_bus_volts_i(dc_bus_volts_i), .gate_enable_o(gate_enable_o),
  .brake_gate_o(brake_gate_o), .overvoltage_fault_o(overvoltage_fault_o),
  .resistor_overload_fault_o(resistor_overload_fault_o), .torque_ref_clear_o(torque_ref_clear_o));

// [tb/dsb_plant.sv]
// Purpose: Shaft speed model.
// Assumes: Ramp codes of the package.
// Notes: The shaft coasts down without firing.
`timescale 1ns/100ps
module dsb_plant import dsb_pkg::*; (
  input  wire logic      core_clk_i, // Clock.
  input  wire logic      reset_n_i,  // Reset.
  input  wire logic      gate_i,     // Firing.
  input  wire dsb_ramp_t ramp_i,     // Ramp.
  output logic           zero_o      // Standstill.
);
  logic [4:0] s_q;
  // Speed rises on accel and falls on decel or coast.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) s_q <= 5'h00;
    else if (ramp_i == DSB_RAMP_ZERO) s_q <= 5'h00;
    else if (gate_i && ramp_i == DSB_RAMP_ACCEL) s_q <= s_q + {4'h0, s_q < 5'h14};
    else if (s_q != 5'h00 && (!gate_i || ramp_i == DSB_RAMP_DECEL)) s_q <= s_q - 5'h01;
  end
  assign zero_o = (s_q == 5'h00);
endmodule

// [tb/dsb_ctrl_tb.sv]
// Purpose: Bench for dsb_ctrl.
// Assumes: Class 2, brake level 675 V.
// Notes: Small tick and overload counts.
`timescale 1ns/100ps
module dsb_ctrl_tb import dsb_pkg::*;;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, zero, gate, rev, clr, brk, ov, rol, jg, key = 0, remote = 0;
  logic [7:0] ad = 8'h00;
  logic [31:0] wd = 32'h0, rdat;
  logic [5:0] din = 6'h00;
  logic [10:0] bus = 11'h000;
  dsb_ramp_t ramp, seen, er;
  int failures = 0, n_tests = 0, cyc = 0, n_clr = 0, m;
  always #2 clk = ~clk;
  dsb_ctrl #(.TICK_CYCLES(4), .ROL_TICKS(8)) u_dut (.core_clk_i(clk), .reset_n_i(rst_n), .reg_addr_i(ad),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .din_i(din), .remote_sel_i(remote),
    .keypad_jog_i(key), .fieldbus_jog_i(4'h0), .run_cmd_i(1'b0), .stop_cmd_i(1'b0), .speed_zero_i(zero),
    .dc_bus_volts_i(bus), .gate_enable_o(gate), .ramp_mode_o(ramp), .reverse_o(rev), .jog_o(jg),
    .torque_ref_clear_o(clr), .brake_gate_o(brk), .overvoltage_fault_o(ov), .resistor_overload_fault_o(rol));
  dsb_plant u_plant (.core_clk_i(clk), .reset_n_i(rst_n), .gate_i(gate), .ramp_i(ramp), .zero_o(zero));
  // Timeout, clear pulse count and stop ramp capture.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (clr === 1'b1) n_clr <= n_clr + 1;
    if (ramp === DSB_RAMP_DECEL || ramp === DSB_RAMP_ZERO) seen <= ramp;
    if (cyc == 5000) begin
      failures++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("Error %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic pass(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Drives pins and bus voltage at a rising edge, then lets the outputs settle.
  task automatic drv(input logic [5:0] d, input logic [10:0] b);
    @(posedge clk) begin
      din <= d;
      bus <= b;
    end
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) begin
      ad <= a;
      wd <= d;
      wr <= 1'b1;
    end
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clk) begin
      ad <= a;
      rd <= 1'b1;
    end
    @(posedge clk) rd <= 1'b0;
    #1 chk(nm, e, rdat);
  endtask
  // Waits for the gate level; a stop also waits for standstill.
  task automatic waitg(input logic v);
    for (int k = 0; k < 400 && (gate !== v || (!v && zero !== 1'b1)); k++) pass(1);
  endtask
  task automatic results();
    if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence: registers, stop modes, direction, brake and faults.
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rreg(8'h00, 32'h00020021, "cfg");
    rreg(8'h04, 32'h000002A3, "brk");
    rreg(8'h1C, 32'h0, "hole");
    wreg(8'h0C, 32'h00005476);
    drv(6'h02, bus);
    for (int i = 0; i < 6; i++) begin
      m = (i == 5) ? 3 : i;
      wreg(8'h00, {12'h0, 4'h2, (i == 5) ? 4'h0 : 4'h4, 1'b0, 3'(m), 8'h21});
      drv(6'h03, bus);
      waitg(1'b1);
      drv(6'h02, bus);
      n_clr = 0;
      seen = DSB_RAMP_HOLD;
      chk("start", DSB_RAMP_ACCEL, ramp);
      drv(6'h00, bus);
      waitg(1'b0);
      // The clear pulse is counted one edge after it stands.
      pass(1);
      er = (m == 1) ? DSB_RAMP_HOLD : (m == 0 || m == 3) ? DSB_RAMP_DECEL : DSB_RAMP_ZERO;
      chk("ramp", er, seen);
      chk("clear", (m > 2 && i < 5), n_clr);
      drv(6'h02, bus);
    end
    // Keypad jog in the local situation, then no jog input in the remote one.
    @(posedge clk) key <= 1'b1;
    waitg(1'b1);
    chk("jog", 1'b1, jg);
    @(posedge clk) key <= 1'b0;
    waitg(1'b0);
    chk("jogoff", 1'b0, jg);
    @(posedge clk) begin
      remote <= 1'b1;
      key    <= 1'b1;
    end
    pass(8);
    chk("remote", 1'b0, gate);
    @(posedge clk) key <= 1'b0;
    drv(6'h0A, bus);
    waitg(1'b1);
    chk("rev", 1'b1, rev);
    drv(6'h02, bus);
    waitg(1'b0);
    drv(6'h06, bus);
    waitg(1'b1);
    chk("fwd", 1'b0, rev);
    // The bench bus is unregulated, as with regulation at its class maximum.
    drv(din, 11'h2BC);
    pass(100);
    chk("brake", 1'b1, brk);
    chk("rol0", 1'b0, rol);
    drv(din, 11'h258);
    pass(3);
    chk("boff", 1'b0, brk);
    drv(din, 11'h384);
    pass(3);
    chk("ov", 1'b1, ov);
    chk("gate", 1'b0, gate);
    drv(din, 11'h000);
    wreg(8'h10, 32'h2);
    pass(3);
    chk("ovclr", 1'b0, ov);
    wreg(8'h04, 32'h000102A3);
    wreg(8'h08, 32'h1);
    drv(din, 11'h2BC);
    pass(300);
    chk("rol", 1'b1, rol);
    results();
  end
endmodule
